// ---- design/cdfs_supervisor.v ----
`timescale 1ns/10ps
`default_nettype none
`include "cdfs_consts.vh"
module cdfs_supervisor #(
  parameter [35:0] DC_CYCLES = `CDFS_DC_CYCLES
) (
  input  wire       i_core_clk,
  input  wire       i_nrst,
  input  wire       i_sleep_n_in,
  input  wire       i_amp_sel_lo,
  input  wire       i_amp_sel_hi,
  input  wire       i_over_current,
  input  wire [7:0] i_die_temp,
  input  wire [7:0] i_mod_duty,
  input  wire       i_pwm_tick,
  input  wire [7:0] i_in_diff_mv,
  input  wire       i_in_diff_neg,
  output reg        o_fault_n,
  output reg        o_bridge_pos_drive,
  output reg        o_bridge_neg_drive,
  output reg        o_bridge_pos_oe,
  output reg        o_bridge_neg_oe,
  output reg        o_shutdown,
  output reg        o_dc_fault,
  output reg        o_short_fault,
  output reg        o_thermal_sd,
  output reg  [1:0] o_gain_code
);
  localparam [2:0] ST_HOLD = 3'b001;
  localparam [2:0] ST_RUN  = 3'b010;
  localparam [2:0] ST_OFF  = 3'b100;
  // constants at the widths of the signals they meet
  localparam [9:0] DEV_LIMIT  = `CDFS_DEV_LIMIT;  // widest gap still within 14%
  localparam [7:0] THR_G20    = `CDFS_THR_G20_MV;
  localparam [7:0] THR_G26    = `CDFS_THR_G26_MV;
  localparam [7:0] THR_G32    = `CDFS_THR_G32_MV;
  localparam [7:0] THR_G36    = `CDFS_THR_G36_MV;
  localparam [7:0] TRIP_DEG   = `CDFS_TRIP_DEG;
  localparam [7:0] RESUME_DEG = `CDFS_TRIP_DEG - `CDFS_HYST_DEG;

  wire       sleep_n_s;
  wire       oc_s;
  wire       sel_lo_s;
  wire       sel_hi_s;
  reg  [2:0] state_ff;
  reg  [2:0] nxt_state;
  reg  [7:0] ramp_ff;
  reg        pol_ff;
  reg        dev_act_ff;
  reg  [35:0] tmr_ff;
  reg  [7:0] thr_mv;
  wire [8:0] dev_mag;
  wire [9:0] diff_mag;
  wire       dev_pos;
  wire       dev_over;
  wire       in_over;
  wire       cond;
  wire       stop_out;
  wire       pos_pwm;
  wire       neg_pwm;

  // pin inputs pass two flops
  cdfs_sync2 #(.RST_VAL(1'b0)) u_sync_sleep (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_async    (i_sleep_n_in),
    .o_sync     (sleep_n_s)
  );
  cdfs_sync2 #(.RST_VAL(1'b0)) u_sync_oc (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_async    (i_over_current),
    .o_sync     (oc_s)
  );
  cdfs_sync2 #(.RST_VAL(1'b0)) u_sync_lo (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_async    (i_amp_sel_lo),
    .o_sync     (sel_lo_s)
  );
  cdfs_sync2 #(.RST_VAL(1'b0)) u_sync_hi (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_async    (i_amp_sel_hi),
    .o_sync     (sel_hi_s)
  );

  always @* begin
    case ({sel_hi_s, sel_lo_s})
      `CDFS_GAIN_20: thr_mv = THR_G20;
      `CDFS_GAIN_26: thr_mv = THR_G26;
      `CDFS_GAIN_32: thr_mv = THR_G32;
      default:       thr_mv = THR_G36;
    endcase
  end

  // differential duty: pos duty minus neg duty
  assign dev_pos  = i_mod_duty >= `CDFS_PWM_HALF;
  assign dev_mag  = dev_pos ? {1'b0, i_mod_duty} - {1'b0, `CDFS_PWM_HALF}
                            : {1'b0, `CDFS_PWM_HALF} - {1'b0, i_mod_duty};
  assign diff_mag = {dev_mag, 1'b0};  // both outputs move, so the gap is twice
  assign dev_over = diff_mag > DEV_LIMIT;
  assign in_over  = i_in_diff_mv >= thr_mv;
  assign cond     = (state_ff == ST_RUN) && (dev_over || in_over);
  // polarity of whichever detector fired
  wire   cur_pol  = dev_over ? dev_pos : !i_in_diff_neg;

  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      tmr_ff     <= 36'h0_0000_0000;
      pol_ff     <= 1'b0;
      dev_act_ff <= 1'b0;
    end else if (!cond || (dev_act_ff && (pol_ff != cur_pol))) begin
      tmr_ff     <= 36'h0_0000_0000;
      pol_ff     <= cur_pol;
      dev_act_ff <= cond;
    end else begin
      dev_act_ff <= 1'b1;
      pol_ff     <= cur_pol;
      if (tmr_ff < DC_CYCLES)
        tmr_ff <= tmr_ff + 36'h0_0000_0001;
    end
  end

  // operating state: hold in sleep, run, or thermal off
  always @* begin
    case (state_ff)
      ST_HOLD: nxt_state = sleep_n_s ? ST_RUN : ST_HOLD;
      ST_RUN: begin
        if (!sleep_n_s)
          nxt_state = ST_HOLD;
        else if (i_die_temp > TRIP_DEG)
          nxt_state = ST_OFF;
        else
          nxt_state = ST_RUN;
      end
      ST_OFF: begin
        if (i_die_temp <= RESUME_DEG)
          nxt_state = sleep_n_s ? ST_RUN : ST_HOLD;
        else
          nxt_state = ST_OFF;
      end
      default: nxt_state = ST_HOLD;
    endcase
  end

  always @(posedge i_core_clk) begin
    if (!i_nrst)
      ramp_ff <= 8'h00;
    else if (i_pwm_tick)
      ramp_ff <= ramp_ff + 8'h01;
  end

  assign pos_pwm  = ramp_ff < i_mod_duty;
  assign neg_pwm  = {1'b0, ramp_ff} < (9'h100 - {1'b0, i_mod_duty});
  assign stop_out = o_dc_fault || o_short_fault || (state_ff != ST_RUN);

  // operating state register
  always @(posedge i_core_clk) begin
    if (!i_nrst)
      state_ff <= ST_HOLD;
    else
      state_ff <= nxt_state;
  end

  // dc fault latch
  // only reset clears
  always @(posedge i_core_clk) begin
    if (!i_nrst)
      o_dc_fault <= 1'b0;
    else if (tmr_ff >= DC_CYCLES)
      o_dc_fault <= 1'b1;
  end

  // short-circuit latch
  // short latch set wins
  always @(posedge i_core_clk) begin
    if (!i_nrst)
      o_short_fault <= 1'b0;
    else if (oc_s && (state_ff == ST_RUN))
      o_short_fault <= 1'b1;
    else if (!sleep_n_s)
      o_short_fault <= 1'b0;
  end

  // alarm and bridge drive
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_fault_n          <= 1'b1;
      o_bridge_pos_drive <= 1'b0;
      o_bridge_neg_drive <= 1'b0;
      o_bridge_pos_oe    <= 1'b0;
      o_bridge_neg_oe    <= 1'b0;
      o_shutdown         <= 1'b1;
      o_thermal_sd       <= 1'b0;
      o_gain_code        <= 2'b00;
    end else begin
      o_fault_n          <= !(o_dc_fault || o_short_fault);
      o_bridge_pos_oe    <= !stop_out;
      o_bridge_neg_oe    <= !stop_out;
      o_bridge_pos_drive <= !stop_out && pos_pwm;
      o_bridge_neg_drive <= !stop_out && neg_pwm;
      o_shutdown         <= stop_out;
      o_thermal_sd       <= (state_ff == ST_OFF);
      o_gain_code        <= {sel_hi_s, sel_lo_s};
    end
  end
endmodule
`default_nettype wire

// ---- design/cdfs_consts.vh ----
// Contract
// - dc fault drives the active-low alarm output low
// - dc fault puts both bridge outputs in high impedance
// - dc fault stays latched; only power-on reset clears it
// - toggling sleep input leaves a latched dc fault untouched
// - duty deviation over 14% same polarity beyond 420 ms raises dc fault
// - per-gain input threshold held over 420 ms triggers dc detect
// - over-current sets short latch and drives alarm low
// - short latch holds both bridge outputs in high impedance
// - short latch clears when sleep input passes through low
// - temperature above trip point shuts down and disables outputs
// - thermal shutdown not latched; resumes after 15 degree fall
// - thermal shutdown never asserts the alarm output
// - outputs switch ground to supply, in phase at zero input
// - positive output: pos duty above half, neg below half
// - negative output: pos duty below half, neg above half
// - gain select high bit first: 20, 26, 32, 36 dB
// - sleep low mutes outputs and enters low-current shutdown
`ifndef CDFS_CONSTS_VH
`define CDFS_CONSTS_VH
`define CDFS_CLK_MHZ       100
`define CDFS_DC_TIME_MS    420
`define CDFS_DC_CYCLES     (`CDFS_DC_TIME_MS * 1000 * `CDFS_CLK_MHZ + 1)
`define CDFS_PWM_BITS      8
`define CDFS_PWM_HALF      8'h80
`define CDFS_DEV_PCT       14
`define CDFS_DEV_LIMIT     ((256 * `CDFS_DEV_PCT) / 100)
`define CDFS_TRIP_DEG      150
`define CDFS_HYST_DEG      15
`define CDFS_TEMP_BITS     8
`define CDFS_THR_G20_MV    112
`define CDFS_THR_G26_MV    56
`define CDFS_THR_G32_MV    28
`define CDFS_THR_G36_MV    17
`define CDFS_GAIN_20       2'b00
`define CDFS_GAIN_26       2'b01
`define CDFS_GAIN_32       2'b10
`define CDFS_GAIN_36       2'b11
`define CDFS_TMR_BITS      36
`endif

// ---- design/cdfs_sync2.v ----
`timescale 1ns/10ps
`default_nettype none
module cdfs_sync2 #(
  parameter RST_VAL = 1'b0
) (
  input  wire i_core_clk,
  input  wire i_nrst,
  input  wire i_async,
  output reg  o_sync
);
  reg meta_ff;
  // two-stage synchroniser
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      meta_ff <= RST_VAL;
      o_sync  <= RST_VAL;
    end else begin
      meta_ff <= i_async;
      o_sync  <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ---- bench/cdfs_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
module cdfs_ctrl (
  input  wire logic i_fault_n,
  input  wire logic i_auto,
  input  wire logic i_sleep_req,
  output wire logic o_sleep_n
);
  // sleep held low until asked, alarm tied back in auto mode
  assign o_sleep_n = i_sleep_req & (i_fault_n | ~i_auto);
endmodule
`default_nettype wire

// ---- bench/cdfs_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module cdfs_checker (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_sleep_n_in,
  input wire logic i_over_current,
  input wire logic o_fault_n,
  input wire logic o_bridge_pos_oe,
  input wire logic o_bridge_neg_oe,
  input wire logic o_shutdown,
  input wire logic o_dc_fault,
  input wire logic o_short_fault,
  input wire logic o_thermal_sd
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // alarm, high impedance and latching of faults
  dc_alarm_a: assert property (o_dc_fault |=> !o_fault_n)
    else $error("alarm not low on dc fault");
  dc_hiz_a: assert property (o_dc_fault |=> !o_bridge_pos_oe && !o_bridge_neg_oe)
    else $error("bridge driven during dc fault");
  dc_latch_a: assert property (o_dc_fault |=> o_dc_fault)
    else $error("dc fault cleared without reset");
  dc_run_a: assert property ($rose(o_dc_fault) |-> $past(o_bridge_pos_oe))
    else $error("dc fault raised outside run");
  short_set_a: assert property ($rose(o_short_fault) |-> $past(i_over_current, 2) ||
    $past(i_over_current, 3) || $past(i_over_current, 4))
    else $error("short fault without over-current");
  short_hiz_a: assert property (o_short_fault |=> !o_bridge_pos_oe && !o_bridge_neg_oe)
    else $error("bridge driven during short fault");
  therm_off_a: assert property (o_thermal_sd && $past(o_thermal_sd) |->
    !o_bridge_pos_oe && !o_bridge_neg_oe)
    else $error("bridge driven in thermal shutdown");
  alarm_free_a: assert property (!o_dc_fault && !o_short_fault |=> o_fault_n)
    else $error("alarm low with no fault latched");
  sleep_off_a: assert property (!i_sleep_n_in [*4] |=>
    o_shutdown && !o_bridge_pos_oe && !o_bridge_neg_oe)
    else $error("outputs active while asleep");
endmodule
bind cdfs_supervisor cdfs_checker u_cdfs_checker (.*);
`default_nettype wire

// ---- bench/class_d_fault_supervisor_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
// compare one value, count and report
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module class_d_fault_supervisor_bench;
  localparam int DC = 20;
  logic clk, nrst, req, aut, lo, hi, oc, tick, neg;
  logic [7:0] temp, duty, mv;
  wire logic sl, fn, pd, nd, po, no, sd, dcf, scf, th;
  wire logic [1:0] gc;
  int n_mismatch, checked, pc, nc, ph, i, g;
  cdfs_supervisor #(.DC_CYCLES(36'd20)) u_cdfs_supervisor (.i_core_clk(clk), .i_nrst(nrst),
    .i_sleep_n_in(sl), .i_amp_sel_lo(lo), .i_amp_sel_hi(hi), .i_over_current(oc),
    .i_die_temp(temp), .i_mod_duty(duty), .i_pwm_tick(tick), .i_in_diff_mv(mv),
    .i_in_diff_neg(neg), .o_fault_n(fn), .o_bridge_pos_drive(pd), .o_bridge_neg_drive(nd),
    .o_bridge_pos_oe(po), .o_bridge_neg_oe(no), .o_shutdown(sd), .o_dc_fault(dcf),
    .o_short_fault(scf), .o_thermal_sd(th), .o_gain_code(gc));
  cdfs_ctrl u_cdfs_ctrl (.i_fault_n(fn), .i_auto(aut), .i_sleep_req(req), .o_sleep_n(sl));
  // input threshold for each gain step
  function automatic logic [7:0] thr(input int k);
    return k == 0 ? 8'h70 : k == 1 ? 8'h38 : k == 2 ? 8'h1c : 8'h11;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // power cycle with sleep held low, then wake
  task automatic boot(input logic [1:0] gs);
    nrst <= 1'b0;
    req <= 1'b0;
    {hi, lo} <= gs;
    temp <= 8'($urandom_range(134));
    cyc(8);
    nrst <= 1'b1;
    cyc(4);
    req <= 1'b1;
    cyc(10);
  endtask
  task automatic pulse_oc();
    oc <= 1'b1;
    cyc(1);
    oc <= 1'b0;
    cyc(6);
  endtask
  task automatic print_verdict();
    $display("counts: checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end
  // test sequence
  initial begin
    {nrst, req, aut, lo, hi, oc, neg} = 7'h00;
    tick = 1'b1;
    temp = 8'h19;
    duty = 8'h80;
    mv = 8'h00;
    n_mismatch = 0;
    checked = 0;
    i = $urandom(19075);
    boot(2'b00);
    for (i = 0; i < 6; i++) begin
      duty <= (i == 0) ? 8'h80 : 8'h6f + 8'($urandom_range(34));
      cyc(8);
      {pc, nc, ph} = 0;
      repeat (512) begin
        @(posedge clk);
        pc += pd;
        nc += nd;
        ph += (pd != nd);
      end
      `CHK("pos_duty", duty > 8'h80, pc > 256)
      `CHK("neg_duty", duty < 8'h80, nc > 256)
      if (i == 0) `CHK("in_phase", 0, ph)
    end
    $display("test pwm done");
    duty <= 8'h91;
    cyc(3 * DC);
    `CHK("dc_band", 1'b0, dcf)
    for (i = 0; i < 4; i++) begin
      duty <= i[0] ? 8'h6e : 8'h92;
      cyc(DC - 3);
    end
    `CHK("dc_flip", 1'b0, dcf)
    duty <= 8'h92;
    cyc(DC + 6);
    `CHK("dc_set", 1'b1, dcf)
    `CHK("dc_alarm", 1'b0, fn)
    `CHK("dc_hiz", 1'b0, po | no)
    req <= 1'b0;
    cyc(6);
    req <= 1'b1;
    duty <= 8'h80;
    cyc(10);
    `CHK("dc_sleep", 1'b1, dcf)
    boot(2'b00);
    `CHK("dc_power", 1'b0, dcf)
    $display("test duty dc done");
    for (g = 0; g < 4; g++) begin
      boot(g[1:0]);
      `CHK("gain", g[1:0], gc)
      neg <= g[0];
      mv <= thr(g) - 8'h01;
      cyc(3 * DC);
      `CHK("thr_below", 1'b0, dcf)
      mv <= thr(g);
      cyc(DC + 6);
      `CHK("thr_hit", 1'b1, dcf)
    end
    mv <= 8'h00;
    $display("test input dc done");
    boot(2'b00);
    pulse_oc();
    `CHK("short_set", 2'b10, {scf, fn})
    `CHK("short_hiz", 1'b0, po | no)
    req <= 1'b0;
    cyc(4);
    req <= 1'b1;
    cyc(12);
    `CHK("short_clr", 2'b01, {scf, fn})
    aut <= 1'b1;
    pulse_oc();
    cyc(30);
    `CHK("auto_rec", 2'b01, {scf, po})
    aut <= 1'b0;
    req <= 1'b0;
    cyc(6);
    `CHK("sleep_off", 2'b10, {sd, po})
    req <= 1'b1;
    cyc(10);
    $display("test short done");
    temp <= 8'h96;
    cyc(6);
    `CHK("temp_150", 1'b0, th)
    temp <= 8'h97;
    cyc(6);
    `CHK("temp_trip", 3'b101, {th, po, fn})
    temp <= 8'h88;
    cyc(6);
    `CHK("temp_hold", 1'b1, th)
    temp <= 8'h87;
    cyc(10);
    `CHK("temp_resume", 2'b01, {th, po})
    $display("test thermal done");
    print_verdict();
  end
endmodule
`default_nettype wire
